// ===== core/cag_pkg.sv
// constants, register map and carrier types for the crane axis gate
// assumes a 20 MHz mclk and an APB master with 32-bit data
package cag_pkg;

    localparam int AXES    = 2;                    // index 0 crane, 1 trolley
    localparam int SPD_W   = 16;                   // speed in mm/s
    localparam int PCT_W   = 8;                    // whole percent
    localparam int ENDP_W  = 10;                   // end speed in 0.1 percent
    localparam int TIME_W  = 16;                   // milliseconds
    localparam int ADDR_W  = 8;

    // timing
    localparam int CLK_NS    = 50;
    localparam int MS_NS     = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;     // mclk cycles per millisecond, rounds down

    // percentage scales
    localparam logic [PCT_W-1:0]  PCT_FULL  = 8'h64;   // 100 percent
    localparam logic [ENDP_W-1:0] ENDP_FULL = 10'h3E8; // 100.0 percent in tenths

    // register map, one block of eight words per axis
    localparam logic [ADDR_W-1:0] AXIS_STRIDE = 8'h20;
    localparam logic [4:0] OFS_ACT     = 5'h00;
    localparam logic [4:0] OFS_COMFORT = 5'h04;
    localparam logic [4:0] OFS_ENDSPD  = 5'h08;
    localparam logic [4:0] OFS_ENDTIME = 5'h0C;
    localparam logic [4:0] OFS_MAXSPD  = 5'h10;
    localparam logic [4:0] OFS_SLOWREF = 5'h14;
    localparam logic [4:0] OFS_FASTREF = 5'h18;
    localparam logic [4:0] OFS_STATUS  = 5'h1C;

    // reset values of the settings
    localparam logic [PCT_W-1:0]  RST_ACT     = 8'h00;
    localparam logic [PCT_W-1:0]  RST_COMFORT = 8'h64;
    localparam logic [ENDP_W-1:0] RST_ENDSPD  = 10'h006;
    localparam logic [TIME_W-1:0] RST_ENDTIME = 16'h0320;
    localparam logic [SPD_W-1:0]  RST_MAXSPD  = 16'h03E8;
    localparam logic [SPD_W-1:0]  RST_SLOWREF = 16'h012C;
    localparam logic [SPD_W-1:0]  RST_FASTREF = 16'h03E8;

    typedef enum logic [1:0] {CAG_IDLE, CAG_RUN, CAG_STOP, CAG_HALT} cag_state_t;

    typedef struct packed {
        logic [PCT_W-1:0]  act;
        logic [PCT_W-1:0]  comfort;
        logic [ENDP_W-1:0] endSpd;
        logic [TIME_W-1:0] endTime;
        logic [SPD_W-1:0]  maxSpd;
        logic [SPD_W-1:0]  slowRef;
        logic [SPD_W-1:0]  fastRef;
    } cag_cfg_t;

    // travel switches, each bit low when the switch is active
    typedef struct packed {
        logic fwdEnd;
        logic revEnd;
        logic fwdSlow;
        logic revSlow;
    } cag_sw_t;

    typedef struct packed {
        logic fwd;
        logic rev;
        logic high;
    } cag_run_t;

    // orders to the axis drive
    typedef struct packed {
        logic [SPD_W-1:0] speedRef;
        logic [PCT_W-1:0] corrGain;
        logic             corrOn;
        logic             lowSpeed;
        logic             quickStop;
        logic             dirFwd;
    } cag_drv_t;

endpackage

// ===== core/cag_axis_gate.sv
// crane axis gate: supervision of crane and trolley axes, APB settings
// assumes switch, run and enable pins are asynchronous; axisSpeed comes
// from drive feedback logic on mclk as an unsigned magnitude in mm/s
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module cag_axis_gate import cag_pkg::*; #(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire cag_sw_t              travelSwitchN [AXES],
    input  wire cag_run_t             runPins [AXES],
    input  wire logic                 assistEnable,
    input  wire logic [SPD_W-1:0]     axisSpeed [AXES],
    output cag_drv_t                  driveOrder [AXES],
    output logic                      assistActivity,
    output logic                      craneReady
);

    // pin synchronisers, first stage read only by the second
    cag_sw_t    swMeta_reg [AXES];
    cag_sw_t    swSync_reg [AXES];
    cag_run_t   runMeta_reg [AXES];
    cag_run_t   runSync_reg [AXES];
    logic       enMeta_reg;
    logic       enSync_reg;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int a = 0; a < AXES; a++) begin
                swMeta_reg[a]  <= '1;
                swSync_reg[a]  <= '1;
                runMeta_reg[a] <= '0;
                runSync_reg[a] <= '0;
            end
            enMeta_reg <= 1'b0;
            enSync_reg <= 1'b0;
        end else begin
            swMeta_reg  <= travelSwitchN;
            swSync_reg  <= swMeta_reg;
            runMeta_reg <= runPins;
            runSync_reg <= runMeta_reg;
            enMeta_reg  <= assistEnable;
            enSync_reg  <= enMeta_reg;
        end
    end

    // state
    cag_cfg_t           cfg_reg [AXES],      cfg_next [AXES];
    cag_state_t         state_reg [AXES],    state_next [AXES];
    logic               dirFwd_reg [AXES],   dirFwd_next [AXES];
    logic               endLock_reg [AXES],  endLock_next [AXES];
    logic               slowLock_reg [AXES], slowLock_next [AXES];
    logic               maxSeen_reg [AXES],  maxSeen_next [AXES];
    logic [TIME_W-1:0]  endCnt_reg [AXES],   endCnt_next [AXES];
    cag_drv_t           drv_reg [AXES],      drv_next [AXES];
    logic [31:0]        msCnt_reg,           msCnt_next;
    logic               activity_reg,        activity_next;
    logic               ready_reg,           ready_next;
    logic [31:0]        rdata_reg,           rdata_next;
    logic               pready_reg,          pready_next;
    logic               perr_reg,            perr_next;

    // derived per-axis quantities and the millisecond tick
    cag_sw_t            sw [AXES];
    logic [SPD_W-1:0]   actSpd [AXES];
    logic [SPD_W-1:0]   endSpd [AXES];
    logic               msTick;

    always_comb begin
        msTick = (msCnt_reg == 32'(MS_TICK_CYCLES - 1));
        for (int a = 0; a < AXES; a++) begin
            sw[a]     = ~swSync_reg[a];
            actSpd[a] = SPD_W'((32'(cfg_reg[a].act) * 32'(cfg_reg[a].maxSpd))
                        / 32'(PCT_FULL));
            endSpd[a] = SPD_W'((32'(cfg_reg[a].endSpd) * 32'(cfg_reg[a].maxSpd))
                        / 32'(ENDP_FULL));
        end
    end

    // APB slave: one wait-free access phase, answers registered in setup
    logic               setup;
    logic               access;
    logic [ADDR_W-1:0]  axOfs;
    logic               axIdx;
    logic               mapped;

    always_comb begin
        setup  = psel && !penable;
        access = psel && penable && pready_reg;
        axIdx  = (paddr >= AXIS_STRIDE);
        axOfs  = axIdx ? (paddr - AXIS_STRIDE) : paddr;
        mapped = (paddr < (AXIS_STRIDE << 1)) && (paddr[1:0] == 2'b00);
        pready_next = setup;
        perr_next   = setup && !mapped;
        rdata_next  = '0;
        if (setup && !pwrite && mapped) begin
            case (axOfs[4:0])
                OFS_ACT:     rdata_next = 32'(cfg_reg[axIdx].act);
                OFS_COMFORT: rdata_next = 32'(cfg_reg[axIdx].comfort);
                OFS_ENDSPD:  rdata_next = 32'(cfg_reg[axIdx].endSpd);
                OFS_ENDTIME: rdata_next = 32'(cfg_reg[axIdx].endTime);
                OFS_MAXSPD:  rdata_next = 32'(cfg_reg[axIdx].maxSpd);
                OFS_SLOWREF: rdata_next = 32'(cfg_reg[axIdx].slowRef);
                OFS_FASTREF: rdata_next = 32'(cfg_reg[axIdx].fastRef);
                OFS_STATUS:  rdata_next = {24'h000000, drv_reg[axIdx].quickStop,
                                 drv_reg[axIdx].corrOn, slowLock_reg[axIdx],
                                 endLock_reg[axIdx], dirFwd_reg[axIdx],
                                 1'b0, state_reg[axIdx]};
                default:     rdata_next = '0;
            endcase
        end
        // separate settings per axis
        cfg_next = cfg_reg;
        if (access && pwrite && mapped) begin
            case (axOfs[4:0])
                OFS_ACT:     cfg_next[axIdx].act     = pwdata[PCT_W-1:0];
                OFS_COMFORT: cfg_next[axIdx].comfort = pwdata[PCT_W-1:0];
                OFS_ENDSPD:  cfg_next[axIdx].endSpd  = pwdata[ENDP_W-1:0];
                OFS_ENDTIME: cfg_next[axIdx].endTime = pwdata[TIME_W-1:0];
                OFS_MAXSPD:  cfg_next[axIdx].maxSpd  = pwdata[SPD_W-1:0];
                OFS_SLOWREF: cfg_next[axIdx].slowRef = pwdata[SPD_W-1:0];
                OFS_FASTREF: cfg_next[axIdx].fastRef = pwdata[SPD_W-1:0];
                default:     cfg_next[axIdx] = cfg_reg[axIdx];
            endcase
        end
    end

    // axis supervision, evaluated on every clock
    logic endDir [AXES];
    logic slowDir [AXES];
    logic runDir [AXES];
    logic startFwd [AXES];
    logic startRev [AXES];
    logic [SPD_W-1:0] ref_ [AXES];

    always_comb begin
        msCnt_next    = msTick ? '0 : msCnt_reg + 32'h00000001;
        ready_next    = 1'b1;
        activity_next = 1'b0;
        for (int a = 0; a < AXES; a++) begin
            state_next[a]    = state_reg[a];
            dirFwd_next[a]   = dirFwd_reg[a];
            maxSeen_next[a]  = maxSeen_reg[a];
            endCnt_next[a]   = endCnt_reg[a];
            // standstill latches: either switch counts as both
            endLock_next[a]  = (state_reg[a] == CAG_IDLE && (sw[a].fwdEnd || sw[a].revEnd))
                ? 1'b1 : (endLock_reg[a] && (sw[a].fwdEnd || sw[a].revEnd));
            slowLock_next[a] = (state_reg[a] == CAG_IDLE && (sw[a].fwdSlow || sw[a].revSlow))
                ? 1'b1 : (slowLock_reg[a] && (sw[a].fwdSlow || sw[a].revSlow));
            // the switch of the recorded direction acts, and either switch while its standstill lock is held
            endDir[a]  = (dirFwd_reg[a] ? sw[a].fwdEnd : sw[a].revEnd)
                         || endLock_reg[a];
            slowDir[a] = (dirFwd_reg[a] ? sw[a].fwdSlow : sw[a].revSlow)
                         || slowLock_reg[a];
            runDir[a]  = dirFwd_reg[a] ? runSync_reg[a].fwd : runSync_reg[a].rev;
            // a start is refused toward an active end switch, and in both directions while the end lock is held
            startFwd[a] = runSync_reg[a].fwd && !runSync_reg[a].rev
                          && !sw[a].fwdEnd && !endLock_reg[a];
            startRev[a] = runSync_reg[a].rev && !runSync_reg[a].fwd
                          && !sw[a].revEnd && !endLock_reg[a];
            ref_[a] = (slowDir[a] || !runSync_reg[a].high) ? cfg_reg[a].slowRef
                                                           : cfg_reg[a].fastRef;
            case (state_reg[a])
                CAG_IDLE: begin
                    if (startFwd[a] || startRev[a]) begin
                        state_next[a]   = CAG_RUN;
                        dirFwd_next[a]  = startFwd[a];
                        maxSeen_next[a] = 1'b0;
                    end
                end
                CAG_RUN: begin
                    if (axisSpeed[a] >= cfg_reg[a].maxSpd)
                        maxSeen_next[a] = 1'b1;
                    if (endDir[a])
                        state_next[a] = CAG_HALT;
                    else if (!runDir[a]) begin
                        state_next[a]  = CAG_STOP;
                        endCnt_next[a] = '0;
                    end
                end
                CAG_STOP: begin
                    // speed must dwell at end speed for the end time
                    if (endDir[a])
                        state_next[a] = CAG_HALT;
                    else if (runDir[a])
                        state_next[a] = CAG_RUN;
                    else if (axisSpeed[a] > endSpd[a])
                        endCnt_next[a] = '0;
                    else if (endCnt_next[a] >= cfg_reg[a].endTime)
                        state_next[a] = CAG_IDLE;
                    else if (msTick)
                        endCnt_next[a] = endCnt_reg[a] + 16'h0001;
                end
                CAG_HALT: begin
                    if (axisSpeed[a] <= endSpd[a])
                        state_next[a] = CAG_IDLE;
                end
                default: state_next[a] = CAG_IDLE;
            endcase
            // drive orders
            drv_next[a]           = '0;
            drv_next[a].dirFwd    = dirFwd_next[a];
            drv_next[a].quickStop = (state_next[a] == CAG_HALT);
            drv_next[a].lowSpeed  = (state_next[a] == CAG_RUN) && slowDir[a];
            drv_next[a].speedRef  = (state_next[a] == CAG_RUN) ? ref_[a] : '0;
            drv_next[a].corrOn    = enSync_reg
                && (state_next[a] == CAG_RUN || state_next[a] == CAG_STOP)
                && (maxSeen_next[a] || ref_[a] > actSpd[a])
                && !(slowDir[a] && axisSpeed[a] > cfg_reg[a].slowRef);
            drv_next[a].corrGain  = drv_next[a].corrOn ? cfg_reg[a].comfort : '0;
            // activity lasts while any assisted movement is unfinished
            if (enSync_reg && (state_next[a] == CAG_RUN || state_next[a] == CAG_STOP))
                activity_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int a = 0; a < AXES; a++) begin
                cfg_reg[a]      <= '{RST_ACT, RST_COMFORT, RST_ENDSPD, RST_ENDTIME,
                                     RST_MAXSPD, RST_SLOWREF, RST_FASTREF};
                state_reg[a]    <= CAG_IDLE;
                dirFwd_reg[a]   <= 1'b0;
                endLock_reg[a]  <= 1'b0;
                slowLock_reg[a] <= 1'b0;
                maxSeen_reg[a]  <= 1'b0;
                endCnt_reg[a]   <= '0;
                drv_reg[a]      <= '0;
            end
            msCnt_reg    <= '0;
            activity_reg <= 1'b0;
            ready_reg    <= 1'b0;
            rdata_reg    <= '0;
            pready_reg   <= 1'b0;
            perr_reg     <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            state_reg    <= state_next;
            dirFwd_reg   <= dirFwd_next;
            endLock_reg  <= endLock_next;
            slowLock_reg <= slowLock_next;
            maxSeen_reg  <= maxSeen_next;
            endCnt_reg   <= endCnt_next;
            drv_reg      <= drv_next;
            msCnt_reg    <= msCnt_next;
            activity_reg <= activity_next;
            ready_reg    <= ready_next;
            rdata_reg    <= rdata_next;
            pready_reg   <= pready_next;
            perr_reg     <= perr_next;
        end
    end

    assign driveOrder     = drv_reg;
    assign assistActivity = activity_reg;
    assign craneReady     = ready_reg;
    assign prdata         = rdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = perr_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    AST_NO_CORR_WITHOUT_ENABLE: assert property (
        !enSync_reg |=> !drv_reg[0].corrOn && !drv_reg[1].corrOn)
        else $error("correction applied while assistance disabled");
    AST_QUICKSTOP_NO_CORR: assert property (
        drv_reg[0].quickStop |-> !drv_reg[0].corrOn && drv_reg[0].speedRef == '0)
        else $error("quick stop with corrections or speed");
    AST_END_SWITCH_HALTS: assert property (
        state_reg[0] == CAG_RUN && dirFwd_reg[0] && sw[0].fwdEnd
        |=> drv_reg[0].quickStop)
        else $error("forward end switch did not halt crane");
    AST_BELOW_THRESHOLD_LINEAR: assert property (
        state_next[1] == CAG_RUN && !maxSeen_next[1] && ref_[1] <= actSpd[1]
        |=> !drv_reg[1].corrOn)
        else $error("trolley corrected below threshold");
    AST_GAIN_IS_COMFORT: assert property (
        drv_reg[0].corrOn |-> drv_reg[0].corrGain == $past(cfg_reg[0].comfort))
        else $error("correction gain differs from comfort");
    AST_STOP_WAITS: assert property (
        state_reg[0] == CAG_STOP && axisSpeed[0] > endSpd[0] && !runDir[0]
        && !endDir[0] |=> state_reg[0] == CAG_STOP)
        else $error("movement ended above end speed");
    AST_LOCK_BLOCKS_START: assert property (
        endLock_reg[0] && state_reg[0] == CAG_IDLE |=> state_reg[0] != CAG_RUN)
        else $error("crane started while end lock held");
    AST_SLOW_LOW_ORDER: assert property (
        state_next[0] == CAG_RUN && slowLock_reg[0] |=> drv_reg[0].lowSpeed
        && drv_reg[0].speedRef == $past(cfg_reg[0].slowRef))
        else $error("slow lock without low speed order");
    AST_ACTIVITY_LOW_IDLE: assert property (
        state_reg[0] == CAG_IDLE && state_reg[1] == CAG_IDLE
        && $stable(state_reg[0]) && $stable(state_reg[1])
        |-> ##0 !assistActivity)
        else $error("activity high with both axes idle");
    AST_READY_AFTER_RESET: assert property (
        ##2 1'b1 |-> craneReady)
        else $error("crane ready not high");

endmodule

// ===== tb/cag_drive_model.sv
// axis drive model: measured speed follows the ordered reference
// assumes orders come from the gate on the same mclk
`timescale 1ns/10ps
module cag_drive_model import cag_pkg::*; #(
    parameter int STEP = 50
) (
    input  wire logic             mclk,
    input  wire cag_drv_t         order,
    output logic      [SPD_W-1:0] speed
);
    int s = 0;
    int r;
    assign r = int'(order.speedRef);
    // linear ramp; quick stop brakes four times harder, never below zero
    always @(posedge mclk) begin
        if (order.quickStop)
            s <= (s > 4 * STEP) ? s - 4 * STEP : 0;
        else if (s + STEP < r)
            s <= s + STEP;
        else if (s - STEP > r)
            s <= s - STEP;
        else
            s <= r;
    end
    assign speed = s[SPD_W-1:0];
endmodule

// ===== tb/cag_axis_gate_bench.sv
// bench for the crane axis gate: APB settings, pin stimulus, drive models
// assumes cag_pkg, the gate and the drive model are compiled first
`timescale 1ns/10ps
module cag_axis_gate_bench import cag_pkg::*;;
    logic              mclk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic              assistEnable, assistActivity, craneReady;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q, lf;
    cag_sw_t           sw [AXES];
    cag_run_t          run [AXES];
    logic [SPD_W-1:0]  spd [AXES];
    cag_drv_t          ord [AXES];
    int                failures = 0, nTests = 0, cyc = 0, c;

    cag_axis_gate #(.MS_TICK_CYCLES(10)) u_cag_axis_gate (.mclk, .rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .travelSwitchN(sw),
        .runPins(run), .assistEnable, .axisSpeed(spd), .driveOrder(ord), .assistActivity,
        .craneReady);
    for (genvar i = 0; i < AXES; i++) begin : g_axis
        cag_drive_model u_cag_drive_model (.mclk, .order(ord[i]), .speed(spd[i]));
    end

    always #25 mclk = ~mclk;
    // hang guard, the sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            stop_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // reference model of the correction gate
    function automatic logic corrExp(input int en, input int act, input int rf);
        return en != 0 && rf * 100 > act * int'(RST_MAXSPD);
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        nTests++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", n, x, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pins(input int a, input cag_sw_t s, input cag_run_t r);
        @(posedge mclk);
        sw[a] <= s;
        run[a] <= r;
    endtask
    // request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no timeout here; if pready never rises only the hang guard ends this wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stop_test();
        if (failures == 0 && nTests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        logic [31:0] rv [7];
        rv = '{32'(RST_ACT), 32'(RST_COMFORT), 32'(RST_ENDSPD), 32'(RST_ENDTIME),
               32'(RST_MAXSPD), 32'(RST_SLOWREF), 32'(RST_FASTREF)};
        mclk = 0;
        rstn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        assistEnable = 0;
        sw = '{default: 4'hF};
        run = '{default: 3'h0};
        lf = 32'hB13B;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        tick(1);
        chk("ready", 1, craneReady);
        for (int a = 0; a < AXES; a++)
            for (int i = 0; i < 7; i++) begin
                apb(0, 8'(a * 32 + 4 * i), 0);
                chk("setting", rv[i], q);
            end
        apb(0, 8'h40, 0);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, q);
        lf = lfsr(lf);
        c = int'(lf % 101);
        apb(1, 8'h20, 45); // trolley only; crane keeps zero
        apb(1, 8'h04, c);
        apb(1, 8'h0C, 3);
        apb(1, 8'h2C, 3);
        apb(0, 8'h04, 0);
        chk("comfort", c, q);
        assistEnable <= 1'b1;
        pins(0, 4'hF, 3'h4);
        pins(1, 4'hF, 3'h4);
        tick(4);
        chk("crane corr", corrExp(1, 0, 300), ord[0].corrOn);
        chk("trolley corr", corrExp(1, 45, 300), ord[1].corrOn);
        chk("slow ref", RST_SLOWREF, ord[1].speedRef);
        chk("gain", c, ord[0].corrGain);
        pins(0, 4'hF, 3'h5);
        pins(1, 4'hF, 3'h5);
        tick(4);
        chk("trolley corr hi", corrExp(1, 45, 1000), ord[1].corrOn);
        tick(25);
        pins(1, 4'hF, 3'h0);
        tick(16);
        chk("corr in stop", 1, ord[1].corrOn);
        pins(0, 4'h7, 3'h5);
        tick(4);
        chk("quick stop", 1, ord[0].quickStop);
        chk("corr cut", 0, ord[0].corrOn);
        pins(0, 4'hF, 3'h0);
        tick(10);
        chk("activity hold", 1, assistActivity);
        tick(50);
        chk("activity end", 0, assistActivity);
        pins(0, 4'hF, 3'h3);
        tick(4);
        chk("rev ref", 1000, ord[0].speedRef);
        chk("rev dir", 0, ord[0].dirFwd);
        chk("rev corr", 1, ord[0].corrOn);
        pins(0, 4'hD, 3'h3);
        tick(4);
        chk("leave slow", 0, ord[0].lowSpeed);
        chk("leave ref", 1000, ord[0].speedRef);
        @(posedge mclk);
        assistEnable <= 1'b0;
        tick(4);
        chk("disabled", 0, ord[0].corrOn);
        pins(0, 4'hF, 3'h0);
        assistEnable <= 1'b1;
        tick(60);
        pins(0, 4'hF, 3'h5);
        tick(30);
        pins(0, 4'hD, 3'h5);
        tick(4);
        chk("slow low", 1, ord[0].lowSpeed);
        chk("slow corr", 0, ord[0].corrOn);
        tick(20);
        chk("slow resume", 1, ord[0].corrOn);
        pins(0, 4'hF, 3'h5);
        pins(0, 4'hF, 3'h0);
        tick(60);
        pins(0, 4'hB, 3'h0);
        pins(0, 4'hB, 3'h5);
        tick(4);
        chk("locked ref", 0, ord[0].speedRef);
        apb(0, 8'h1C, 0);
        chk("lock flag", 1, q[4]);
        pins(0, 4'hF, 3'h5);
        tick(4);
        chk("unlocked ref", 1000, ord[0].speedRef);
        pins(0, 4'hF, 3'h0);
        tick(60);
        // reverse slow switch at standstill also slows forward motion
        pins(0, 4'hE, 3'h0);
        pins(0, 4'hE, 3'h5);
        tick(4);
        chk("slow lock low", 1, ord[0].lowSpeed);
        chk("slow lock ref", RST_SLOWREF, ord[0].speedRef);
        apb(0, 8'h1C, 0);
        chk("slow lock flag", 1, q[5]);
        stop_test();
    end
endmodule
